/* pwm_deadtime_fault_update_ctrl.sv */
// module: update control, trigger postscaler, dead-time insertion and fault a handling of a 3-pair pwm
// =========================================================
// What this block does
// - special event trigger output divided by postscale code plus one, 1:1 to 1:16.
// - immediate-update bit set applies duty writes at once, else at time base sync.
// - override-sync bit set applies overrides at time base sync, else next cycle.
// - update-disable bit set freezes transfer of buffered duty and period values.
// - dead-time unit b prescale bits 15-14 select 1, 2, 4 or 8 cycles per count.
// - dead-time unit a prescale bits 7-6 select 1, 2, 4 or 8 cycles per count.
// - unit b count in bits 13-8, unit a count in bits 5-0, unsigned 6 bits.
// - per generator, active-edge select bit picks unit b when 1, unit a when 0.
// - per generator, inactive-edge select bit picks unit b when 1, unit a when 0.
// - on fault a each of six pins goes to its own programmed override level.
// - fault a mode bit 1 selects cycle-by-cycle handling.
// - fault a mode bit 0 latches controlled pins into their override levels.
// - each pair obeys fault a only while its enable is 1; enables reset to 1.
// - fault a control register is write-protected behind the unlock sequence.
// - no internal comparator path into the fault logic; only the fault pin.
// - unimplemented register bits read zero and ignore writes.
// - with write lock option set, protected writes need the unlock key first.
`timescale 1ns/1ps

module pwm_deadtime_fault_update_ctrl
#(
	parameter logic [15:0] UNLOCK_KEY_FIRST  = 16'hA5C3,	// arbitrary value
	parameter logic [15:0] UNLOCK_KEY_SECOND = 16'h3C5A		// arbitrary value
)
(
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	// register port
	input  wire pwm_ctrl_pkg::reg_req_s  reg_req,
	output      logic [15:0]             reg_rdata,
	// configuration option
	input  wire logic                    write_lock_option,
	// time base events and buffered values
	input  wire logic                    period_event,
	input  wire logic                    special_event,
	input  wire pwm_ctrl_pkg::duty_set_t duty_buf,
	input  wire logic [14:0]             period_buf,
	input  wire pwm_ctrl_pkg::override_s override_req,
	// values handed to the generators
	output      pwm_ctrl_pkg::duty_set_t duty_active,
	output      logic [14:0]             period_active,
	output      logic                    trigger_out,
	// generators and pins
	input  wire logic [2:0]              gen_raw,
	input  wire logic                    fault_a_input_pin,
	output      logic [5:0]              pwm_pins
);
	import pwm_ctrl_pkg::*;

	// =========================================================
	// state
	typedef struct packed
	{
		logic [15:0]     pwm_update_control;
		logic [15:0]     dead_time_units_setup;
		logic [15:0]     dead_time_edge_select;
		logic [15:0]     fault_a_control;
		logic            key_stage;
		logic            unlocked;
		duty_set_t       duty;
		logic [14:0]     period;
		override_s       ovr;
		logic [3:0]      sev_cnt;
		logic            trig;
		logic [2:0]      fsync;
		logic            fault;
		logic            latched;
		logic            cbc;
		logic [2:0]      gen_q;
		logic [2:0][8:0] dt_cnt;
		logic [2:0]      dead_h;
		logic [2:0]      dead_l;
		logic [5:0]      pins;
		logic [15:0]     rdata;
	} state_s;

	state_s s;
	state_s next_s;

	// =========================================================
	// helpers
	// dead time in clock cycles: count shifted by the prescale code
	function automatic logic [8:0] dt_cycles(input logic [5:0] cnt, input logic [1:0] ps);
		dt_cycles = 9'({3'h0, cnt} << ps);
	endfunction

	function automatic logic hit(input reg_req_s r, input logic [3:0] idx);
		hit = r.wr && (r.addr == idx);
	endfunction

	logic       immediate_duty_update;
	logic       override_sync_sel;
	logic       buffer_update_disable;
	logic [3:0] postscale;
	logic [8:0] unit_a;
	logic [8:0] unit_b;
	logic [5:0] fault_ov;
	logic       fault_mode;
	logic [2:0] fault_en;
	logic [2:0] fault_on;
	logic       fault_wr_ok;

	always_comb
	begin
		immediate_duty_update = s.pwm_update_control[POS_IMM_UPDATE];
		override_sync_sel     = s.pwm_update_control[POS_OVR_SYNC];
		buffer_update_disable = s.pwm_update_control[POS_UPD_FREEZE];
		postscale  = s.pwm_update_control[POS_POSTSCALE +: 4];
		unit_b     = dt_cycles(s.dead_time_units_setup[POS_UNIT_B_CNT +: 6],
			s.dead_time_units_setup[POS_UNIT_B_PS +: 2]);
		unit_a     = dt_cycles(s.dead_time_units_setup[POS_UNIT_A_CNT +: 6],
			s.dead_time_units_setup[POS_UNIT_A_PS +: 2]);
		fault_ov   = s.fault_a_control[POS_FAULT_OV +: 6];
		fault_mode = s.fault_a_control[POS_FAULT_MD];
		fault_en   = s.fault_a_control[POS_FAULT_EN +: 3];
		// only the fault pin feeds this logic, no comparator path exists
		fault_on   = fault_en & {3{s.latched | s.cbc}};
		// key is spent by the protected write that it opens
		fault_wr_ok = !write_lock_option || s.unlocked;
	end

	// =========================================================
	// next state
	always_comb
	begin
		logic [8:0] load;
		logic       g;
		load   = 9'h000;
		g      = 1'b0;
		next_s = s;

		// register writes, unimplemented bits masked
		if (hit(reg_req, IDX_UPDATE_CTRL))
		begin
			next_s.pwm_update_control = reg_req.wdata & UPDATE_CTRL_MASK;
		end
		if (hit(reg_req, IDX_DT_SETUP))
		begin
			next_s.dead_time_units_setup = reg_req.wdata & DT_SETUP_MASK;
		end
		if (hit(reg_req, IDX_DT_EDGE_SEL))
		begin
			next_s.dead_time_edge_select = reg_req.wdata & DT_EDGE_SEL_MASK;
		end
		if (hit(reg_req, IDX_FAULT_A_CTRL))
		begin
			if (fault_wr_ok)
			begin
				next_s.fault_a_control = reg_req.wdata & FAULT_A_CTRL_MASK;
			end
			next_s.unlocked = 1'b0;
		end
		if (hit(reg_req, IDX_UNLOCK_KEY))
		begin
			next_s.key_stage = (reg_req.wdata == UNLOCK_KEY_FIRST);
			if (s.key_stage && reg_req.wdata == UNLOCK_KEY_SECOND)
			begin
				next_s.unlocked = 1'b1;
			end
		end

		// read data stands only in the cycle after the strobe
		next_s.rdata = 16'h0000;
		if (reg_req.rd)
		begin
			unique case (reg_req.addr)
				IDX_UPDATE_CTRL:  next_s.rdata = s.pwm_update_control;
				IDX_DT_SETUP:     next_s.rdata = s.dead_time_units_setup;
				IDX_DT_EDGE_SEL:  next_s.rdata = s.dead_time_edge_select;
				IDX_FAULT_A_CTRL: next_s.rdata = s.fault_a_control;
				IDX_STATUS:       next_s.rdata = {10'h000, s.unlocked, s.key_stage,
					s.cbc, s.latched, s.fault, s.trig};
				default:          next_s.rdata = 16'h0000;
			endcase
		end

		// buffered value transfer
		if (!buffer_update_disable)
		begin
			if (immediate_duty_update || period_event)
			begin
				next_s.duty = duty_buf;
			end
			if (period_event)
			begin
				next_s.period = period_buf;
			end
		end

		// output override transfer
		if (!override_sync_sel || period_event)
		begin
			next_s.ovr = override_req;
		end

		// special event postscaler
		next_s.trig = 1'b0;
		if (special_event)
		begin
			if (s.sev_cnt >= postscale)
			begin
				next_s.sev_cnt = 4'h0;
				next_s.trig    = 1'b1;
			end
			else
			begin
				next_s.sev_cnt = s.sev_cnt + 4'h1;
			end
		end

		// fault pin filter: a level counts once stages two and three agree
		next_s.fsync = {s.fsync[1:0], fault_a_input_pin};
		if (s.fsync[1] == s.fsync[2])
		begin
			next_s.fault = s.fsync[2];
		end
		// latch releases only by a write while the pin is quiet; a fault wins over it
		if (hit(reg_req, IDX_FAULT_A_CTRL) && fault_wr_ok && !s.fault)
		begin
			next_s.latched = 1'b0;
		end
		if (s.fault && !fault_mode)
		begin
			next_s.latched = 1'b1;
		end
		// cycle-by-cycle override drops at the first period boundary without fault
		next_s.cbc = (s.fault && fault_mode) || (s.cbc && !period_event);

		// dead-time insertion, one counter per generator
		next_s.gen_q = gen_raw;
		for (int p = 0; p < 3; p++)
		begin
			g = gen_raw[p];
			if (g != s.gen_q[p])
			begin
				if (g)
				begin
					load = s.dead_time_edge_select[2 * p + 1] ? unit_b : unit_a;
				end
				else
				begin
					load = s.dead_time_edge_select[2 * p] ? unit_b : unit_a;
				end
				next_s.dead_h[p] = 1'b0;
				next_s.dead_l[p] = 1'b0;
				next_s.dt_cnt[p] = 9'h000;
				if (load == 9'h000)
				begin
					next_s.dead_h[p] = g;
					next_s.dead_l[p] = !g;
				end
				else
				begin
					next_s.dt_cnt[p] = load - 9'h001;
				end
			end
			else if (s.dt_cnt[p] != 9'h000)
			begin
				next_s.dt_cnt[p] = s.dt_cnt[p] - 9'h001;
			end
			else
			begin
				next_s.dead_h[p] = g;
				next_s.dead_l[p] = !g;
			end
		end

		// pin selection: fault over manual override over generator
		for (int p = 0; p < 3; p++)
		begin
			next_s.pins[2 * p + 1] = s.ovr.release_to_gen[2 * p + 1] ? s.dead_h[p]
				: s.ovr.manual_level[2 * p + 1];
			next_s.pins[2 * p] = s.ovr.release_to_gen[2 * p] ? s.dead_l[p]
				: s.ovr.manual_level[2 * p];
			if (fault_on[p])
			begin
				next_s.pins[2 * p + 1] = fault_ov[2 * p + 1];
				next_s.pins[2 * p]     = fault_ov[2 * p];
			end
		end
	end

	// =========================================================
	// registers
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			s                       <= '0;
			s.pwm_update_control    <= UPDATE_CTRL_RST;
			s.dead_time_units_setup <= DT_SETUP_RST;
			s.dead_time_edge_select <= DT_EDGE_SEL_RST;
			s.fault_a_control       <= FAULT_A_CTRL_RST;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign reg_rdata     = s.rdata;
	assign duty_active   = s.duty;
	assign period_active = s.period;
	assign trigger_out   = s.trig;
	assign pwm_pins      = s.pins;

	// =========================================================
	// checks
	a_trig_first_event: assert property (@(posedge clk) disable iff (!reset_n)
		special_event && (s.sev_cnt >= postscale) |=> trigger_out)
		else $error("postscaler missed its event");

	a_trig_counting: assert property (@(posedge clk) disable iff (!reset_n)
		special_event && (s.sev_cnt < postscale) |=> !trigger_out)
		else $error("postscaler fired early");

	a_duty_immediate: assert property (@(posedge clk) disable iff (!reset_n)
		immediate_duty_update && !buffer_update_disable |=> duty_active == $past(duty_buf))
		else $error("immediate duty update not applied");

	a_duty_sync_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!immediate_duty_update && !period_event && !reg_req.wr |=> $stable(duty_active))
		else $error("duty changed off the time base");

	a_update_frozen: assert property (@(posedge clk) disable iff (!reset_n)
		buffer_update_disable && !reg_req.wr |=> $stable(duty_active) && $stable(period_active))
		else $error("buffer transfer while disabled");

	a_override_sync: assert property (@(posedge clk) disable iff (!reset_n)
		!override_sync_sel |=> s.ovr == $past(override_req))
		else $error("override not applied next cycle");

	a_override_wait: assert property (@(posedge clk) disable iff (!reset_n)
		override_sync_sel && !period_event && !reg_req.wr |=> $stable(s.ovr))
		else $error("override applied off the time base");

	a_fault_pins: assert property (@(posedge clk) disable iff (!reset_n)
		fault_on[0] |=> pwm_pins[1:0] == $past(fault_ov[1:0]))
		else $error("fault override level wrong");

	a_fault_latch_hold: assert property (@(posedge clk) disable iff (!reset_n)
		s.latched && !hit(reg_req, IDX_FAULT_A_CTRL) |=> s.latched)
		else $error("latched fault released without a write");

	a_fault_cbc_release: assert property (@(posedge clk) disable iff (!reset_n)
		s.cbc && !s.fault && period_event && !s.latched |=> !s.cbc)
		else $error("cycle-by-cycle override not released");

	a_fault_cbc_set: assert property (@(posedge clk) disable iff (!reset_n)
		s.fault && fault_mode |=> s.cbc)
		else $error("cycle-by-cycle override not taken");

	a_fault_cbc_hold: assert property (@(posedge clk) disable iff (!reset_n)
		s.cbc && !period_event |=> s.cbc)
		else $error("cycle-by-cycle override dropped early");

	a_pair_ignored: assert property (@(posedge clk) disable iff (!reset_n)
		!fault_en[1] && s.ovr.release_to_gen[3:2] == 2'b00
		|=> pwm_pins[3:2] == $past(s.ovr.manual_level[3:2]))
		else $error("disabled pair followed the fault");

	a_lock_blocks: assert property (@(posedge clk) disable iff (!reset_n)
		hit(reg_req, IDX_FAULT_A_CTRL) && write_lock_option && !s.unlocked
		|=> $stable(s.fault_a_control))
		else $error("locked fault register was written");

	a_dead_gap: assert property (@(posedge clk) disable iff (!reset_n)
		gen_raw[0] && !s.gen_q[0] && !s.dead_time_edge_select[1] && unit_a == 9'h003
		|=> !s.dead_h[0] ##1 !s.dead_h[0] ##1 !s.dead_h[0] ##1 s.dead_h[0])
		else $error("active edge dead time wrong");
endmodule

/* pwm_ctrl_pkg.sv */
// package: register map, field layout, reset values and carrier types of the pwm control block
package pwm_ctrl_pkg;

	// =========================================================
	// register indices on the plain register port
	localparam logic [3:0]  IDX_UPDATE_CTRL  = 4'h0;
	localparam logic [3:0]  IDX_DT_SETUP     = 4'h1;
	localparam logic [3:0]  IDX_DT_EDGE_SEL  = 4'h2;
	localparam logic [3:0]  IDX_FAULT_A_CTRL = 4'h3;
	localparam logic [3:0]  IDX_UNLOCK_KEY   = 4'h4;
	localparam logic [3:0]  IDX_STATUS       = 4'h5;

	// =========================================================
	// implemented-bit masks and reset values
	localparam logic [15:0] UPDATE_CTRL_MASK  = 16'h0F07;
	localparam logic [15:0] DT_SETUP_MASK     = 16'hFFFF;
	localparam logic [15:0] DT_EDGE_SEL_MASK  = 16'h003F;
	localparam logic [15:0] FAULT_A_CTRL_MASK = 16'h3F87;
	localparam logic [15:0] UPDATE_CTRL_RST   = 16'h0000;
	localparam logic [15:0] DT_SETUP_RST      = 16'h0000;
	localparam logic [15:0] DT_EDGE_SEL_RST   = 16'h0000;
	localparam logic [15:0] FAULT_A_CTRL_RST  = 16'h0007;

	// =========================================================
	// field positions
	localparam int POS_POSTSCALE  = 8;
	localparam int POS_IMM_UPDATE = 2;
	localparam int POS_OVR_SYNC   = 1;
	localparam int POS_UPD_FREEZE = 0;
	localparam int POS_UNIT_B_PS  = 14;
	localparam int POS_UNIT_B_CNT = 8;
	localparam int POS_UNIT_A_PS  = 6;
	localparam int POS_UNIT_A_CNT = 0;
	localparam int POS_FAULT_OV   = 8;
	localparam int POS_FAULT_MD   = 7;
	localparam int POS_FAULT_EN   = 0;

	// =========================================================
	// carrier types
	typedef logic [2:0][15:0] duty_set_t;

	typedef struct packed
	{
		logic [5:0] release_to_gen;
		logic [5:0] manual_level;
	} override_s;

	typedef struct packed
	{
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_s;

endpackage

/* gate_driver_model.sv */
// behavioural model of the gate-driver stage behind the pwm pins, with its protection trip line
`timescale 1ns/1ps

module gate_driver_model
(
	// clock
	input  wire logic       clk,
	// commands from the block and the bench
	input  wire logic [5:0] pwm_pins,
	input  wire logic       trip,
	// responses
	output      logic [5:0] gate_level,
	output      logic       fault_a_input_pin
);
	// =========================================================
	// gate stage and protection
	initial
	begin
		gate_level = 6'h00;
		fault_a_input_pin = 1'b0;
	end

	// a trip reaches the block only through the dedicated fault pin, never by an internal path
	always @(posedge clk)
	begin
		gate_level <= pwm_pins;
		fault_a_input_pin <= trip;
	end
endmodule

/* pwm_deadtime_fault_update_ctrl_tb_top.sv */
// self-checking testbench of the pwm update, dead-time and fault a control block
`timescale 1ns/1ps

module pwm_deadtime_fault_update_ctrl_tb_top;
	import pwm_ctrl_pkg::*;
	// =========================================================
	// signals
	localparam logic [15:0] KEY1 = 16'h5AA5;	// arbitrary value
	localparam logic [15:0] KEY2 = 16'hC33C;	// arbitrary value
	logic        clk         = 1'b0;
	logic        reset_n     = 1'b0;
	reg_req_s    reg_req     = '0;
	logic [15:0] rdata;
	logic        lock        = 1'b0;
	logic        pe          = 1'b0;
	logic        se          = 1'b0;
	duty_set_t   duty_buf    = '0;
	logic [14:0] period_buf  = '0;
	override_s   ovr         = '0;
	duty_set_t   duty_active;
	logic [14:0] period_active;
	logic        trig;
	logic [2:0]  gen         = '0;
	logic        trip        = 1'b0;
	logic        fault;
	logic [5:0]  pins;
	logic [5:0]  gate;
	int          error_cnt   = 0;
	int          comparisons = 0;
	int          trig_seen   = 0;
	int          overlap     = 0;
	int          da;
	int          db;
	logic [15:0] v;
	logic [15:0] rst_tab [4] = '{UPDATE_CTRL_RST, DT_SETUP_RST, DT_EDGE_SEL_RST, FAULT_A_CTRL_RST};
	logic [15:0] msk_tab [4] = '{UPDATE_CTRL_MASK, DT_SETUP_MASK, DT_EDGE_SEL_MASK, FAULT_A_CTRL_MASK};
	int          codes [3]   = '{0, 1, 15};

	always #4 clk = ~clk;

	always @(posedge clk)
	begin
		if (trig === 1'b1)
			trig_seen++;
		// both switches of one leg on at once would short the supply
		if ((gate & (gate >> 1) & 6'h15) != 6'h00)
			overlap++;
	end

	pwm_deadtime_fault_update_ctrl #(.UNLOCK_KEY_FIRST(KEY1), .UNLOCK_KEY_SECOND(KEY2)) uut
	(
		.clk(clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(rdata), .write_lock_option(lock),
		.period_event(pe), .special_event(se), .duty_buf(duty_buf), .period_buf(period_buf),
		.override_req(ovr), .duty_active(duty_active), .period_active(period_active),
		.trigger_out(trig), .gen_raw(gen), .fault_a_input_pin(fault), .pwm_pins(pins)
	);

	gate_driver_model drv
	(
		.clk(clk), .pwm_pins(pins), .trip(trip), .gate_level(gate), .fault_a_input_pin(fault)
	);

	// =========================================================
	// tasks
	task automatic check(input string n, input logic [47:0] e, input logic [47:0] g);
		comparisons++;
		if (g !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %0h seen %0h", n, e, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		reg_req.wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe is taken
	task automatic rdchk(input string n, input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		reg_req.rd <= 1'b0;
		#1;
		v = rdata;
		check(n, 48'(e), 48'(v));
	endtask

	task automatic pchk(input string n, input logic [5:0] e);
		@(negedge clk);
		check(n, 48'(e), 48'(pins));
		@(posedge clk);
	endtask

	task automatic pulse_period();
		@(posedge clk);
		pe <= 1'b1;
		@(posedge clk);
		pe <= 1'b0;
	endtask

	function automatic logic [15:0] fv(input logic [5:0] ov, input logic m, input logic [2:0] en);
		return {2'b00, ov, m, 4'h0, en};
	endfunction

	// latency has a fixed offset, so only differences between two settings are compared
	task automatic meas(input int p, input logic val, output int n);
		@(posedge clk);
		gen[p] <= ~val;
		tick(80);
		gen[p] <= val;
		n = 0;
		@(posedge clk);
		#1;
		while (pins[2 * p + val] !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// =========================================================
	// watchdog
	initial
	begin
		#400000;
		error_cnt++;
		close_out();
	end

	// =========================================================
	// tests
	initial
	begin
		tick(8);
		reset_n <= 1'b1;
		for (int i = 0; i < 4; i++)
			rdchk("reset value", 4'(i), rst_tab[i]);
		for (int i = 0; i < 4; i++)
		begin
			wr(4'(i), 16'hFFFF);
			rdchk("implemented bits", 4'(i), msk_tab[i]);
		end
		wr(4'h6, 16'hFFFF);
		rdchk("unmapped", 4'h6, 16'h0000);
		tick(1);
		lock <= 1'b1;
		wr(IDX_FAULT_A_CTRL, 16'h0000);
		rdchk("locked write", IDX_FAULT_A_CTRL, FAULT_A_CTRL_MASK);
		wr(IDX_UNLOCK_KEY, KEY1);
		wr(IDX_UNLOCK_KEY, KEY2);
		rdchk("unlock status", IDX_STATUS, 16'h0020);
		wr(IDX_FAULT_A_CTRL, 16'h0007);
		rdchk("unlocked write", IDX_FAULT_A_CTRL, 16'h0007);
		wr(IDX_FAULT_A_CTRL, 16'h0000);
		rdchk("relocked", IDX_FAULT_A_CTRL, 16'h0007);
		tick(1);
		lock <= 1'b0;
		for (int i = 0; i < 3; i++)
			wr(4'(i), 16'h0000);
		$display("test registers done");
		// back-to-back events so the divider sees no idle gaps
		for (int i = 0; i < 3; i++)
		begin
			wr(IDX_UPDATE_CTRL, 16'(codes[i] << POS_POSTSCALE));
			trig_seen = 0;
			@(posedge clk);
			se <= 1'b1;
			tick(2 * (codes[i] + 1));
			se <= 1'b0;
			tick(4);
			check("trigger count", 48'd2, 48'(trig_seen));
		end
		$display("test postscale done");
		wr(IDX_UPDATE_CTRL, 16'h0000);
		duty_buf <= 48'h3333_2222_1111;
		period_buf <= 15'h1234;
		tick(4);
		@(negedge clk);
		check("duty held", 48'h0, duty_active);
		pulse_period();
		tick(2);
		@(negedge clk);
		check("duty synced", 48'h3333_2222_1111, duty_active);
		check("period synced", 48'h1234, 48'(period_active));
		wr(IDX_UPDATE_CTRL, 16'h0001);
		duty_buf <= 48'hAAAA_BBBB_CCCC;
		period_buf <= 15'h0555;
		pulse_period();
		tick(2);
		@(negedge clk);
		check("duty frozen", 48'h3333_2222_1111, duty_active);
		check("period frozen", 48'h1234, 48'(period_active));
		wr(IDX_UPDATE_CTRL, 16'h0004);
		tick(3);
		@(negedge clk);
		check("duty immediate", 48'hAAAA_BBBB_CCCC, duty_active);
		check("period waits", 48'h1234, 48'(period_active));
		$display("test update done");
		wr(IDX_UPDATE_CTRL, 16'h0000);
		ovr <= '{release_to_gen: 6'h00, manual_level: 6'h15};
		tick(4);
		pchk("override next cycle", 6'h15);
		wr(IDX_UPDATE_CTRL, 16'h0002);
		ovr <= '{release_to_gen: 6'h00, manual_level: 6'h2A};
		tick(6);
		pchk("override waits", 6'h15);
		pulse_period();
		tick(3);
		pchk("override synced", 6'h2A);
		$display("test override done");
		wr(IDX_UPDATE_CTRL, 16'h0000);
		ovr <= '{release_to_gen: 6'h3F, manual_level: 6'h00};
		for (int k = 0; k < 4; k++)
		begin
			wr(IDX_DT_SETUP, {2'(k), 6'd5, 2'(3 - k), 6'd3});
			for (int p = 0; p < 3; p++)
				for (int e = 0; e < 2; e++)
				begin
					wr(IDX_DT_EDGE_SEL, 16'(1 << (2 * p + e)));
					meas(p, 1'(e), db);
					wr(IDX_DT_EDGE_SEL, 16'h0000);
					meas(p, 1'(e), da);
					check("dead time", 48'((5 << k) - (3 << (3 - k))), 48'(db - da));
				end
		end
		$display("test dead time done");
		wr(IDX_FAULT_A_CTRL, fv(6'h2A, 1'b0, 3'b111));
		ovr <= '{release_to_gen: 6'h00, manual_level: 6'h15};
		trip <= 1'b1;
		tick(12);
		pchk("latched override", 6'h2A);
		trip <= 1'b0;
		tick(12);
		pchk("latch holds", 6'h2A);
		wr(IDX_FAULT_A_CTRL, fv(6'h2A, 1'b0, 3'b001));
		tick(4);
		pchk("latch cleared", 6'h15);
		trip <= 1'b1;
		tick(12);
		pchk("pair enables", 6'h16);
		trip <= 1'b0;
		tick(12);
		wr(IDX_FAULT_A_CTRL, fv(6'h2A, 1'b1, 3'b111));
		trip <= 1'b1;
		tick(12);
		pchk("cycle override", 6'h2A);
		trip <= 1'b0;
		tick(12);
		pchk("cycle holds", 6'h2A);
		pulse_period();
		tick(4);
		pchk("cycle released", 6'h15);
		wr(IDX_FAULT_A_CTRL, fv(6'h00, 1'b0, 3'b000));
		trip <= 1'b1;
		tick(12);
		pchk("fault ignored", 6'h15);
		$display("test fault done");
		check("pair overlap", 48'h0, 48'(overlap));
		close_out();
	end
endmodule
